// [hw/gpio_port_pkg.sv]
package gpio_port_pkg;

    // pin counts and bus sizes
    localparam int unsigned PIN_COUNT = 8;
    localparam int unsigned ANALOG_PIN_COUNT = 6;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] OFF_PIN_DATA = 8'h00;
    localparam logic [7:0] OFF_PIN_DIRECTION = 8'h04;
    localparam logic [7:0] OFF_PULLUP_ENABLE = 8'h08;
    localparam logic [7:0] OFF_CHANGE_IRQ_ENABLE = 8'h0c;
    localparam logic [7:0] OFF_ANALOG_SELECT = 8'h10;
    localparam logic [7:0] OFF_OPTION = 8'h14;
    localparam logic [7:0] OFF_INTERRUPT_CONTROL = 8'h18;
    localparam logic [7:0] OFF_ALT_PIN_FUNCTION_CONTROL = 8'h1c;

    // reset values
    localparam logic [7:0] PIN_DIRECTION_RST = 8'hff;
    localparam logic [7:0] PULLUP_ENABLE_RST = 8'hff;
    localparam logic [7:0] CHANGE_IRQ_ENABLE_RST = 8'h00;
    localparam logic [7:0] ANALOG_SELECT_RST = 8'h3f;
    localparam logic [7:0] PIN_LATCH_RST = 8'h00;
    localparam logic GLOBAL_PULLUP_DISABLE_RST = 1'b1;

    // field positions inside the own control registers
    localparam int unsigned OPT_PULLUP_DISABLE_BIT = 0;
    localparam int unsigned INTCTL_FLAG_BIT = 0;
    localparam int unsigned INTCTL_MASK_BIT = 1;
    localparam int unsigned ALT_CCP_SEL_BIT = 0;

    // pin that carries the second capture/compare function
    localparam int unsigned CCP_PIN_BIT = 3;

    // word index field of a byte address
    localparam int unsigned WORD_LSB = 2;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// [hw/pin_sync.sv]
`timescale 1ns/1ps

// two-stage synchroniser for asynchronous pin levels
module pin_sync #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t s_reg;
    sync_state_t s_next;

    // elaboration check of the width
    if (WIDTH < 1) begin
        $error("pin_sync: WIDTH must be at least one");
    end

    // first stage feeds only the second
    always_comb begin
        s_next = s_reg;
        s_next.stage1 = d;
        s_next.stage2 = s_reg.stage1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.stage2;

endmodule

// [hw/gpio_port.sv]
`timescale 1ns/1ps

// Functional notes
// R1: one pull-up enable per pin; one turns the weak pull-up on.
// R2: global pull-up disable set forces every pull-up off.
// R3: a pin set as output never has its pull-up on.
// R4: one change-detect enable per pin, cleared by reset.
// R5: analog select exists for six low pins; upper bits read zero.
// R6: analog select one disables the pin's digital input buffer.
// R7: digital read of an analog-selected pin returns zero.
// R8: software keeps analog pins set as inputs.
// R9: direction one tri-states the driver; zero drives the latch.
// R10: pin data read returns pin levels; write updates the latch.
// R11: pin data writes are read-modify-write over sampled pin levels.
// R12: direction keeps controlling drivers even on analog pins.
// R13: capture/compare two routes to pin three or neighbour pin one.
// R14: enabled pins mismatching the last-read value set the change flag.
// R15: any pin data access ends mismatch; ongoing mismatch keeps setting flag.
// R16: reset sets the global pull-up disable bit.
// R17: register writes take effect at the edge that ends the write.
module gpio_port #(
    parameter int unsigned ANALOG_PINS = gpio_port_pkg::ANALOG_PIN_COUNT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [gpio_port_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [gpio_port_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [gpio_port_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [gpio_port_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    // port pins
    input wire logic [gpio_port_pkg::PIN_COUNT-1:0] pin_in,
    output logic [gpio_port_pkg::PIN_COUNT-1:0] pin_out,
    output logic [gpio_port_pkg::PIN_COUNT-1:0] pin_oe,
    output logic [gpio_port_pkg::PIN_COUNT-1:0] pullup_on,
    output logic [gpio_port_pkg::PIN_COUNT-1:0] digital_in_enable,
    // change detection
    output logic change_irq,
    // capture/compare two routing
    input wire logic capture_compare_two_out,
    input wire logic capture_compare_two_drive,
    output logic capture_compare_two_in,
    input wire logic neighbour_ccp_pin_in,
    output logic neighbour_ccp_out,
    output logic neighbour_ccp_oe
);

    localparam int unsigned PINS = gpio_port_pkg::PIN_COUNT;
    localparam int unsigned AW = gpio_port_pkg::ADDR_W;
    localparam int unsigned DW = gpio_port_pkg::DATA_W;
    localparam int unsigned WL = gpio_port_pkg::WORD_LSB;
    localparam int unsigned CCP = gpio_port_pkg::CCP_PIN_BIT;

    typedef struct packed {
        // registers
        logic [PINS-1:0] pin_latch;
        logic [PINS-1:0] pin_direction;
        logic [PINS-1:0] pullup_enable;
        logic [PINS-1:0] change_irq_enable;
        logic [ANALOG_PINS-1:0] analog_select;
        logic global_pullup_disable;
        logic change_irq_flag;
        logic change_irq_mask;
        logic ccp_two_pin_select;
        logic [PINS-1:0] last_read;
        // bus slave
        logic aw_held;
        logic [AW-1:0] aw_addr;
        logic w_held;
        logic [PINS-1:0] w_data;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DW-1:0] rdata;
        logic [1:0] rresp;
        // registered pin side outputs
        logic [PINS-1:0] pin_out;
        logic [PINS-1:0] pin_oe;
        logic [PINS-1:0] pullup_on;
        logic [PINS-1:0] digital_in_enable;
        logic change_irq;
        logic ccp_in;
        logic nb_ccp_out;
        logic nb_ccp_oe;
    } port_state_t;

    port_state_t s_reg;
    port_state_t s_next;

    logic [PINS:0] sync_q;
    logic [PINS-1:0] pins_sync;
    logic nb_pin_sync;

    // elaboration check of the analog pin count
    if (ANALOG_PINS < 1 || ANALOG_PINS > PINS) begin
        $error("gpio_port: ANALOG_PINS out of range");
    end

    // pins and neighbour pin cross into the clock domain
    pin_sync #(
        .WIDTH(PINS + 1)
    ) u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .d({neighbour_ccp_pin_in, pin_in}),
        .q(sync_q)
    );

    assign pins_sync = sync_q[PINS-1:0];
    assign nb_pin_sync = sync_q[PINS];

    // register read value for a word address
    function automatic logic [DW-1:0] read_word(
        input port_state_t st,
        input logic [AW-1:0] addr,
        input logic [PINS-1:0] digital,
        output logic hit
    );
        logic [DW-1:0] v;
        v = '0;
        hit = 1'b1;
        unique case (addr[AW-1:WL])
            gpio_port_pkg::OFF_PIN_DATA[AW-1:WL]:
                v[PINS-1:0] = digital; // [R10] [R7]
            gpio_port_pkg::OFF_PIN_DIRECTION[AW-1:WL]:
                v[PINS-1:0] = st.pin_direction;
            gpio_port_pkg::OFF_PULLUP_ENABLE[AW-1:WL]:
                v[PINS-1:0] = st.pullup_enable;
            gpio_port_pkg::OFF_CHANGE_IRQ_ENABLE[AW-1:WL]:
                v[PINS-1:0] = st.change_irq_enable;
            gpio_port_pkg::OFF_ANALOG_SELECT[AW-1:WL]:
                v[ANALOG_PINS-1:0] = st.analog_select; // [R5]
            gpio_port_pkg::OFF_OPTION[AW-1:WL]:
                v[gpio_port_pkg::OPT_PULLUP_DISABLE_BIT] =
                    st.global_pullup_disable;
            gpio_port_pkg::OFF_INTERRUPT_CONTROL[AW-1:WL]: begin
                v[gpio_port_pkg::INTCTL_FLAG_BIT] = st.change_irq_flag;
                v[gpio_port_pkg::INTCTL_MASK_BIT] = st.change_irq_mask;
            end
            gpio_port_pkg::OFF_ALT_PIN_FUNCTION_CONTROL[AW-1:WL]:
                v[gpio_port_pkg::ALT_CCP_SEL_BIT] = st.ccp_two_pin_select;
            default:
                hit = 1'b0;
        endcase
        return v;
    endfunction

    // next state of the whole port
    always_comb begin
        logic [PINS-1:0] ansel_wide;
        logic [PINS-1:0] digital;
        logic [PINS-1:0] mismatch;
        logic aw_fire;
        logic w_fire;
        logic do_write;
        logic [AW-1:0] wa;
        logic [PINS-1:0] wd;
        logic wl0;
        logic rd_hit;
        logic wr_hit;
        logic [DW-1:0] rd_val;
        ansel_wide = '0;
        digital = '0;
        mismatch = '0;
        aw_fire = 1'b0;
        w_fire = 1'b0;
        do_write = 1'b0;
        wa = '0;
        wd = '0;
        wl0 = 1'b0;
        rd_hit = 1'b0;
        wr_hit = 1'b0;
        rd_val = '0;
        s_next = s_reg;

        // analog pins read as zero
        ansel_wide[ANALOG_PINS-1:0] = s_reg.analog_select;
        digital = pins_sync & ~ansel_wide; // [R6] [R7]

        // change detection against the last-read value
        mismatch = (digital ^ s_reg.last_read)
            & s_reg.change_irq_enable; // [R14] [R4]

        // write address and data may arrive in either order
        aw_fire = awvalid && s_reg.awready;
        w_fire = wvalid && s_reg.wready;
        if (aw_fire) begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = awaddr;
        end
        if (w_fire) begin
            s_next.w_held = 1'b1;
            s_next.w_data = wdata[PINS-1:0];
            s_next.w_lane0 = wstrb[0];
        end
        do_write = (s_reg.aw_held || aw_fire) && (s_reg.w_held || w_fire)
            && !s_reg.bvalid;
        wa = s_reg.aw_held ? s_reg.aw_addr : awaddr;
        wd = s_reg.w_held ? s_reg.w_data : wdata[PINS-1:0];
        wl0 = s_reg.w_held ? s_reg.w_lane0 : wstrb[0];

        // register update at the accepting edge
        if (do_write) begin
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.bvalid = 1'b1;
            wr_hit = 1'b1;
            unique case (wa[AW-1:WL])
                gpio_port_pkg::OFF_PIN_DATA[AW-1:WL]: begin
                    // unwritten lane stores the sampled pins
                    s_next.pin_latch = wl0 ? wd : digital; // [R11] [R10]
                    s_next.last_read = digital; // [R15]
                end
                gpio_port_pkg::OFF_PIN_DIRECTION[AW-1:WL]:
                    if (wl0) s_next.pin_direction = wd; // [R17]
                gpio_port_pkg::OFF_PULLUP_ENABLE[AW-1:WL]:
                    if (wl0) s_next.pullup_enable = wd; // [R1]
                gpio_port_pkg::OFF_CHANGE_IRQ_ENABLE[AW-1:WL]:
                    if (wl0) s_next.change_irq_enable = wd; // [R4]
                gpio_port_pkg::OFF_ANALOG_SELECT[AW-1:WL]:
                    if (wl0) begin
                        s_next.analog_select = wd[ANALOG_PINS-1:0]; // [R5]
                    end
                gpio_port_pkg::OFF_OPTION[AW-1:WL]:
                    if (wl0) begin
                        s_next.global_pullup_disable =
                            wd[gpio_port_pkg::OPT_PULLUP_DISABLE_BIT];
                    end
                gpio_port_pkg::OFF_INTERRUPT_CONTROL[AW-1:WL]:
                    if (wl0) begin
                        s_next.change_irq_flag =
                            wd[gpio_port_pkg::INTCTL_FLAG_BIT];
                        s_next.change_irq_mask =
                            wd[gpio_port_pkg::INTCTL_MASK_BIT];
                    end
                gpio_port_pkg::OFF_ALT_PIN_FUNCTION_CONTROL[AW-1:WL]:
                    if (wl0) begin
                        s_next.ccp_two_pin_select =
                            wd[gpio_port_pkg::ALT_CCP_SEL_BIT];
                    end
                default:
                    wr_hit = 1'b0;
            endcase
            s_next.bresp = wr_hit ? gpio_port_pkg::RESP_OKAY
                : gpio_port_pkg::RESP_SLVERR;
        end else if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'b0;
        end

        // read channel
        if (arvalid && s_reg.arready) begin
            rd_val = read_word(s_reg, araddr, digital, rd_hit);
            s_next.rvalid = 1'b1;
            s_next.rdata = rd_val;
            s_next.rresp = rd_hit ? gpio_port_pkg::RESP_OKAY
                : gpio_port_pkg::RESP_SLVERR;
            if (araddr[AW-1:WL]
                == gpio_port_pkg::OFF_PIN_DATA[AW-1:WL]) begin
                s_next.last_read = digital; // [R15]
            end
        end else if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'b0;
        end

        // hardware set beats a software clear in the same cycle
        if (|mismatch) begin
            s_next.change_irq_flag = 1'b1; // [R14] [R15]
        end

        // ready flags follow the held state
        s_next.awready = !s_next.aw_held && !s_next.bvalid;
        s_next.wready = !s_next.w_held && !s_next.bvalid;
        s_next.arready = !s_next.rvalid;

        // pin side outputs from the next register values
        s_next.pin_oe = ~s_next.pin_direction; // [R9] [R12]
        s_next.pin_out = s_next.pin_latch; // [R9]
        if (s_next.ccp_two_pin_select && capture_compare_two_drive) begin
            s_next.pin_out[CCP] = capture_compare_two_out; // [R13]
        end
        s_next.pullup_on = s_next.pullup_enable & s_next.pin_direction
            & {PINS{!s_next.global_pullup_disable}}; // [R1] [R2] [R3]
        ansel_wide[ANALOG_PINS-1:0] = s_next.analog_select;
        s_next.digital_in_enable = ~ansel_wide; // [R6]
        s_next.change_irq = s_next.change_irq_flag && s_next.change_irq_mask;
        s_next.nb_ccp_out = capture_compare_two_out; // [R13]
        s_next.nb_ccp_oe = !s_next.ccp_two_pin_select
            && capture_compare_two_drive; // [R13]
        s_next.ccp_in = s_next.ccp_two_pin_select ? pins_sync[CCP]
            : nb_pin_sync; // [R13]
    end

    // state register with synchronous reset and clock enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.pin_latch <= gpio_port_pkg::PIN_LATCH_RST;
            s_reg.pin_direction <= gpio_port_pkg::PIN_DIRECTION_RST;
            s_reg.pullup_enable <= gpio_port_pkg::PULLUP_ENABLE_RST;
            s_reg.change_irq_enable <=
                gpio_port_pkg::CHANGE_IRQ_ENABLE_RST; // [R4]
            s_reg.analog_select <=
                gpio_port_pkg::ANALOG_SELECT_RST[ANALOG_PINS-1:0];
            s_reg.global_pullup_disable <=
                gpio_port_pkg::GLOBAL_PULLUP_DISABLE_RST; // [R16]
            s_reg.digital_in_enable <= ~gpio_port_pkg::ANALOG_SELECT_RST;
        end else if (ce) begin
            s_reg <= s_next; // [R17]
        end
    end

    // outputs straight from the state register
    assign awready = s_reg.awready;
    assign wready = s_reg.wready;
    assign bvalid = s_reg.bvalid;
    assign bresp = s_reg.bresp;
    assign arready = s_reg.arready;
    assign rvalid = s_reg.rvalid;
    assign rdata = s_reg.rdata;
    assign rresp = s_reg.rresp;
    assign pin_out = s_reg.pin_out;
    assign pin_oe = s_reg.pin_oe;
    assign pullup_on = s_reg.pullup_on;
    assign digital_in_enable = s_reg.digital_in_enable;
    assign change_irq = s_reg.change_irq;
    assign capture_compare_two_in = s_reg.ccp_in;
    assign neighbour_ccp_out = s_reg.nb_ccp_out;
    assign neighbour_ccp_oe = s_reg.nb_ccp_oe;

endmodule

// [verification/gpio_port_chk.sv]
`timescale 1ns/1ps

// bus handshake and pin-side relations at the port block's ports
module gpio_port_chk #(
    parameter int unsigned ANALOG_PINS = 6
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_on,
    input wire logic [7:0] digital_in_enable,
    input wire logic change_irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // pin-side properties
    pullup_out_off_a: assert property (
        (pullup_on & pin_oe) == 8'h00) else $error("pull-up on a driven pin");
    upper_din_on_a: assert property (
        (digital_in_enable >> ANALOG_PINS) == (8'hff >> ANALOG_PINS))
        else $error("input buffer off on a pin with no analog select");
    reset_outs_a: assert property (
        $rose(aresetn) |-> pin_oe == 8'h00 && pullup_on == 8'h00
        && !change_irq) else $error("pin outputs wrong after reset");

    // register bus timing
    write_answer_a: assert property (
        awvalid && awready && wvalid && wready |=> bvalid)
        else $error("no write response one cycle after the write");
    read_answer_a: assert property (
        arvalid && arready |=> rvalid) else $error("read answer late");
    bresp_hold_a: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before bready");
    rdata_hold_a: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data changed before rready");
    busy_refuse_a: assert property (
        bvalid |-> !awready && !wready)
        else $error("new write accepted while response pending");
endmodule

bind gpio_port gpio_port_chk #(.ANALOG_PINS(ANALOG_PINS)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .pin_oe(pin_oe),
    .pullup_on(pullup_on), .digital_in_enable(digital_in_enable),
    .change_irq(change_irq));

// [verification/pin_partner.sv]
`timescale 1ns/1ps

// far-side circuitry on the eight pins
module pin_partner (
    input wire logic aclk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_on,
    input wire logic [7:0] ext_drive,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_level
);
    logic [7:0] float_reg = 8'h55;

    // a pin nobody holds wanders every cycle
    always @(posedge aclk) begin
        float_reg <= ~float_reg;
    end

    // wire level from driver, outside source, pull-up, else floating
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i])
                pin_level[i] = pin_out[i];
            else if (ext_drive[i])
                pin_level[i] = ext_val[i];
            else if (pullup_on[i])
                pin_level[i] = 1'b1;
            else
                pin_level[i] = float_reg[i];
        end
    end
endmodule

// [verification/test_port_pin_control_pullup_ioc.sv]
`timescale 1ns/1ps

// stimulus and scoreboard for the port block
module test_port_pin_control_pullup_ioc;
    typedef struct {
        logic [7:0] a;
        logic wr;
        logic [31:0] d;
        logic [31:0] e;
        logic [1:0] p;
    } row_t;
    logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, change_irq;
    logic [7:0] awaddr, araddr, ext_drive, ext_val, pin_in;
    logic [7:0] pin_out, pin_oe, pullup_on, digital_in_enable;
    logic [31:0] wdata, rdata, v;
    logic [3:0] wstrb;
    logic [2:0] awprot, arprot;
    logic [1:0] bresp, rresp, r;
    logic ccp_out, ccp_drive, ccp_in, nb_in, nb_out, nb_oe;
    int n_mismatch, checks_done, cycles;
    row_t rows[13];

    gpio_port u_dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(awprot),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pullup_on(pullup_on),
        .digital_in_enable(digital_in_enable), .change_irq(change_irq),
        .capture_compare_two_out(ccp_out),
        .capture_compare_two_drive(ccp_drive),
        .capture_compare_two_in(ccp_in), .neighbour_ccp_pin_in(nb_in),
        .neighbour_ccp_out(nb_out), .neighbour_ccp_oe(nb_oe));

    pin_partner u_far (
        .aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_on(pullup_on), .ext_drive(ext_drive), .ext_val(ext_val),
        .pin_level(pin_in));

    // 20 MHz clock
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // hang guard
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // write: address and data together, response taken a cycle late
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [1:0] rsp);
        logic a_ok, w_ok;
        a_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        while (!(a_ok && w_ok)) begin
            @(posedge aclk);
            if (!a_ok && awready) begin
                a_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b1;
        @(posedge aclk);
        rsp = bresp;
        bready <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi_write(a, d, 4'h1, r);
    endtask

    // read: rready raised only after rvalid is seen
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] rsp);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b1;
        @(posedge aclk);
        d = rdata;
        rsp = rresp;
        rready <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        ce = 1'b1;
        {awaddr, araddr, wdata, wstrb, awprot, arprot} = '0;
        ext_drive = 8'hff;
        ext_val = 8'ha5;
        {ccp_out, ccp_drive, nb_in} = 3'h0;
        {n_mismatch, checks_done, cycles} = '0;
        rows = '{
            '{8'h00, 0, 32'h0, 32'h80, 2'h0},
            '{8'h04, 0, 32'h0, 32'hff, 2'h0},
            '{8'h08, 0, 32'h0, 32'hff, 2'h0},
            '{8'h0c, 0, 32'h0, 32'h00, 2'h0},
            '{8'h10, 0, 32'h0, 32'h3f, 2'h0},
            '{8'h14, 0, 32'h0, 32'h01, 2'h0},
            '{8'h18, 0, 32'h0, 32'h00, 2'h0},
            '{8'h1c, 0, 32'h0, 32'h00, 2'h0},
            '{8'h10, 1, 32'hff, 32'h3f, 2'h0},
            '{8'h10, 1, 32'h0, 32'h00, 2'h0},
            '{8'h0c, 1, 32'ha5, 32'ha5, 2'h0},
            '{8'h0c, 1, 32'h0, 32'h00, 2'h0},
            '{8'h40, 1, 32'h1, 32'h00, 2'h2}};
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        // register table, reset values and unmapped place
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axi_write(rows[i].a, rows[i].d, 4'h1, r);
                check(32'(r), 32'(rows[i].p));
            end
            axi_read(rows[i].a, v, r);
            check(v, rows[i].e);
            check(32'(r), 32'(rows[i].p));
        end
        // pull-ups: global disable, per-pin enable, outputs
        check(32'(pullup_on), 32'h0);
        wr(8'h14, 32'h0);
        check(32'(pullup_on), 32'hff);
        ext_drive <= 8'hf0; // low pins left to the pull-ups
        wr(8'h08, 32'h0f);
        check(32'(pullup_on), 32'h0f);
        axi_read(8'h00, v, r);
        check(v, 32'haf);
        wr(8'h04, 32'hf0);
        check(32'({pin_oe, pullup_on}), 32'h0f00);
        // data path, analog masking, read-modify-write
        wr(8'h00, 32'h0d);
        check(32'(pin_out), 32'h0d);
        axi_read(8'h00, v, r);
        check(v, 32'had);
        wr(8'h10, 32'h01);
        check(32'({pin_oe, digital_in_enable}), 32'h0ffe);
        axi_read(8'h00, v, r);
        check(v, 32'hac);
        axi_write(8'h00, 32'hff, 4'h0, r);
        check(32'(pin_out), 32'hac);
        // change detection on pin 7
        wr(8'h10, 32'h0);
        wr(8'h0c, 32'h80);
        axi_read(8'h00, v, r);
        wr(8'h18, 32'h02);
        check(32'(change_irq), 32'h0);
        ext_val <= 8'h25;
        repeat (4) @(posedge aclk);
        check(32'(change_irq), 32'h1);
        wr(8'h18, 32'h02);
        check(32'(change_irq), 32'h1);
        axi_read(8'h00, v, r);
        wr(8'h18, 32'h02);
        check(32'(change_irq), 32'h0);
        ext_val <= 8'h65;
        repeat (4) @(posedge aclk);
        check(32'(change_irq), 32'h0);
        // clock enable low freezes the change detection
        ce <= 1'b0;
        ext_val <= 8'he5;
        repeat (4) @(posedge aclk);
        check(32'(change_irq), 32'h0);
        ce <= 1'b1;
        repeat (4) @(posedge aclk);
        check(32'(change_irq), 32'h1);
        // capture/compare two routing both ways
        ccp_out <= 1'b1;
        ccp_drive <= 1'b1;
        nb_in <= 1'b1;
        repeat (4) @(posedge aclk);
        check(32'({nb_out, nb_oe, ccp_in}), 32'h7);
        ccp_out <= 1'b0;
        wr(8'h1c, 32'h01);
        check(32'({nb_oe, pin_out[3], ccp_in}), 32'h0);
        // second reset in mid-run
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check(32'({pin_oe, pullup_on}), 32'h0);
        @(posedge aclk);
        axi_read(8'h04, v, r);
        check(v, 32'hff);
        report_and_stop();
    end
endmodule
